// File: scc_top.sv
`timescale 1ns/1ns
module scc_top
  import scc_pkg::*;
#(
  parameter int DECIDE_CYC = SCC_DECIDE_CYC // Shorten for simulation
)(
  input wire logic i_clock, // 100 MHz system clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_ce, // Clock enable
  input wire logic i_master_clock_pin, // Clock pin level as input
  input wire logic i_crystal_in_pin, // Oscillator level (crystal)
  input wire logic i_sw_mode, // Software mode active
  input wire logic i_ctrl_wr, // Control port write strobe
  input wire logic [1:0] i_nominal_freq_select, // Frequency field write data
  input wire logic i_clock_out_enable, // Drive clock pin in crystal mode
  input wire logic i_clock_out_halve, // Halve driven clock
  input wire logic i_global_power_down, // Global power-down
  input wire logic i_sclk, // Serial bit clock
  input wire logic i_lrck, // Serial frame clock
  input wire logic i_sdin, // Serial data
  output logic o_master_clock_pin, // Clock pin output value
  output logic o_master_clock_oe, // Clock pin output enable
  output logic o_crystal_out_pin, // Oscillator driver output
  output logic [1:0] o_src, // Chosen source
  output logic o_src_valid, // Source decided
  output logic [1:0] o_freq_eff, // Effective frequency code
  output logic o_ctrl_ready, // Control port may start
  output logic [2:0] o_audio_sync, // Resynchronised sclk, lrck, sdin
  output logic [1:0] o_rate // Measured sample-rate class
);
  scc_src_type src_r;
  logic [1:0] freq_r;
  logic [23:0] decide_cnt_r;
  logic [3:0] edge_cnt_r;
  logic pin_d_r;
  logic [10:0] start_cnt_r;
  logic started_r;
  logic ref_d_r;
  logic div_r;
  logic clk_out_r;
  logic [5:0] wait_cnt_r;
  logic lr_d_r;
  logic [15:0] tick_r;
  logic [15:0] frames_r;
  logic [1:0] rate_r;
  scc_sync_if sif ();

  // Resynchronise serial inputs into the internal domain
  assign sif.raw = {i_sclk, i_lrck, i_sdin};
  scc_sync u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .bus(sif)
  );

  // Frequency field, written only via control port in software mode
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      freq_r <= SCC_FREQ_RESET;
    end else if (i_ce && i_ctrl_wr && i_sw_mode) begin
      freq_r <= i_nominal_freq_select;
    end
  end
  assign o_freq_eff = (freq_r == SCC_FREQ_RSVD) ? SCC_FREQ_18M432 : freq_r;

  // Count toggles on the clock pin during the decision window
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pin_d_r <= 1'b0;
      edge_cnt_r <= 4'h0;
    end else if (i_ce) begin
      pin_d_r <= i_master_clock_pin;
      if (src_r == SCC_SRC_NONE && pin_d_r != i_master_clock_pin && edge_cnt_r != SCC_EDGE_DETECT)
        edge_cnt_r <= edge_cnt_r + 4'h1;
    end
  end

  // Source decision; a live pin clock wins, then held until reset
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      src_r <= SCC_SRC_NONE;
      decide_cnt_r <= 24'h0;
    end else if (i_ce && src_r == SCC_SRC_NONE) begin
      if (edge_cnt_r == SCC_EDGE_DETECT) begin
        src_r <= SCC_SRC_EXT;
      end else if (decide_cnt_r == 24'(DECIDE_CYC - 1)) begin
        src_r <= SCC_SRC_XTAL;
      end else begin
        decide_cnt_r <= decide_cnt_r + 24'h1;
      end
    end
  end
  assign o_src = src_r;
  assign o_src_valid = (src_r != SCC_SRC_NONE);

  // Oscillator driver off in reset; the crystal path only drives after choice
  assign o_crystal_out_pin = (src_r == SCC_SRC_XTAL) ? ~i_crystal_in_pin : 1'b0;

  // Count reference clock periods before driving the master clock
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ref_d_r <= 1'b0;
      start_cnt_r <= 11'h0;
      started_r <= 1'b0;
    end else if (i_ce) begin
      ref_d_r <= i_crystal_in_pin;
      if (!started_r && i_crystal_in_pin && !ref_d_r) begin
        if (start_cnt_r == 11'(SCC_START_PERIODS - 1))
          started_r <= 1'b1;
        else
          start_cnt_r <= start_cnt_r + 11'h1;
      end
    end
  end

  // Output clock: optional halving on each reference rising edge
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      div_r <= 1'b0;
      clk_out_r <= 1'b0;
    end else if (i_ce) begin
      if (i_crystal_in_pin && !ref_d_r)
        div_r <= ~div_r;
      clk_out_r <= i_clock_out_halve ? div_r : ref_d_r;
    end
  end
  // Pin is only driven in crystal mode after the start delay
  assign o_master_clock_oe = (src_r == SCC_SRC_XTAL) && started_r && i_clock_out_enable;
  assign o_master_clock_pin = o_master_clock_oe ? clk_out_r : 1'b0;

  // Control port readiness after the least post-reset wait
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wait_cnt_r <= 6'h0;
    end else if (i_ce && wait_cnt_r != 6'(SCC_CTRL_WAIT_CYC)) begin
      wait_cnt_r <= wait_cnt_r + 6'h1;
    end
  end
  assign o_ctrl_ready = (wait_cnt_r == 6'(SCC_CTRL_WAIT_CYC));
  assign o_audio_sync = sif.sync;

  // Sample-rate measurement: system ticks per fixed frame count
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      lr_d_r <= 1'b0;
      tick_r <= 16'h0;
      frames_r <= 16'h0;
      rate_r <= SCC_RATE_48K;
    end else if (i_ce && !i_global_power_down) begin
      lr_d_r <= sif.sync[1];
      tick_r <= tick_r + 16'h1;
      if (sif.sync[1] && !lr_d_r) begin
        frames_r <= frames_r + 16'h1;
        if (frames_r == 16'h001f) begin
          // 32 frames; tick count scales inversely with rate
          frames_r <= 16'h0;
          tick_r <= 16'h0;
          if (tick_r < 16'h2000) rate_r <= SCC_RATE_96K;
          else if (tick_r < 16'h3800) rate_r <= SCC_RATE_48K;
          else if (tick_r < 16'h4a00) rate_r <= SCC_RATE_44K;
          else rate_r <= SCC_RATE_32K;
        end
      end
    end
  end
  assign o_rate = rate_r;

  // Checks
  property src_hold_p;
    @(posedge i_clock) disable iff (i_rst)
    (i_ce && src_r != SCC_SRC_NONE) |=> (src_r == $past(src_r));
  endproperty
  src_hold_a: assert property (src_hold_p) else $error("source changed");
  decide_bound_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (decide_cnt_r == 24'(DECIDE_CYC - 1) && i_ce) |=> (src_r != SCC_SRC_NONE))
    else $error("no source decision");
  freq_map_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_freq_eff != SCC_FREQ_RSVD) else $error("reserved frequency");
  no_drive_early_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !started_r |-> !o_master_clock_oe) else $error("clock before start");
  ext_no_drive_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (src_r == SCC_SRC_EXT) |-> !o_master_clock_oe) else $error("drives input pin");
  sequence wr_hw_s;
    i_ce && i_ctrl_wr && !i_sw_mode;
  endsequence
  hw_wr_ignore_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_hw_s |=> $stable(freq_r)) else $error("write outside software mode");
  enable_gate_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_clock_out_enable |-> !o_master_clock_oe) else $error("pin not released");
  ready_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_ctrl_ready |=> o_ctrl_ready) else $error("ready dropped");
  osc_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (src_r != SCC_SRC_XTAL) |-> !o_crystal_out_pin) else $error("driver on");
  // Flops hold reset zeros until two enabled edges out of reset have passed
  sync_path_a: assert property (@(posedge i_clock) disable iff (i_rst)
    ((i_ce && !i_rst) [*3]) |-> (o_audio_sync == $past({i_sclk, i_lrck, i_sdin}, 2)))
    else $error("sync mismatch");
  // Start delay ends exactly on the last counted reference period
  start_count_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(started_r) |-> ($past(start_cnt_r) == 11'(SCC_START_PERIODS - 1)))
    else $error("start count wrong");
  ext_pick_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_ce && src_r == SCC_SRC_NONE && edge_cnt_r == SCC_EDGE_DETECT) |=> (src_r == SCC_SRC_EXT))
    else $error("applied clock not chosen");
  ready_time_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_ctrl_ready) |-> ($past(wait_cnt_r) == 6'(SCC_CTRL_WAIT_CYC - 1)))
    else $error("control port ready early");
  // A low enable must freeze the stored field even with a write pending
  ce_freeze_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_ce |=> $stable(freq_r)) else $error("field moved while frozen");
endmodule

// File: scc_pkg.sv
package scc_pkg;
  // Nominal frequency field encodings
  localparam logic [1:0] SCC_FREQ_18M432 = 2'h0;
  localparam logic [1:0] SCC_FREQ_24M576 = 2'h1;
  localparam logic [1:0] SCC_FREQ_27M000 = 2'h2;
  localparam logic [1:0] SCC_FREQ_RSVD = 2'h3;
  localparam logic [1:0] SCC_FREQ_RESET = 2'h0;
  // Input-clock periods between reset release and master clock start
  localparam int SCC_START_PERIODS = 1024;
  // Source decision time and its cycle count at 100 MHz
  localparam int SCC_CLK_PERIOD_NS = 10;
  localparam int SCC_DECIDE_MS = 10;
  localparam int SCC_DECIDE_CYC = (SCC_DECIDE_MS * 1000000) / SCC_CLK_PERIOD_NS;
  // Least wait before the first control-port start
  localparam int SCC_CTRL_WAIT_NS = 500;
  localparam int SCC_CTRL_WAIT_CYC = (SCC_CTRL_WAIT_NS + SCC_CLK_PERIOD_NS - 1) / SCC_CLK_PERIOD_NS;
  // Input-pin edges that count as a live applied clock
  localparam logic [3:0] SCC_EDGE_DETECT = 4'h8;
  // Serial audio frame window constant; unused, the rate measurement in scc_top counts 32 frames
  localparam logic [15:0] SCC_RATE_WINDOW = 16'h8000;
  typedef enum logic [1:0] {SCC_SRC_NONE, SCC_SRC_EXT, SCC_SRC_XTAL} scc_src_type;
  typedef enum logic [1:0] {SCC_RATE_32K, SCC_RATE_44K, SCC_RATE_48K, SCC_RATE_96K} scc_rate_type;
endpackage

// File: scc_sync_if.sv
`timescale 1ns/1ns
interface scc_sync_if;
  logic [2:0] raw; // Async serial audio inputs
  logic [2:0] sync; // Resynchronised copies
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface

// File: scc_sync.sv
`timescale 1ns/1ns
module scc_sync
  import scc_pkg::*;
(
  input wire logic i_clock, // System clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_ce, // Clock enable
  scc_sync_if.dst bus // Raw in, sync out
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  // Two flops; first stage read only by the second
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
    end else if (i_ce) begin
      meta_r <= bus.raw;
      sync_r <= meta_r;
    end
  end
  assign bus.sync = sync_r;
endmodule

// File: scc_src_model.sv
`timescale 1ns/1ns
module scc_src_model (
  input wire logic i_ext_mode, // High: applied clock on pin, crystal grounded
  input wire logic i_run, // Low stops the applied clock
  input wire logic i_pin_oe, // Device drives the clock pin
  input wire logic i_pin_out, // Device clock pin value
  output logic o_pin, // Resolved clock pin level
  output logic o_xtal // Oscillator level at the crystal input
);
  logic osc = 1'b0;
  // 40 ns source, edges kept off the 100 MHz sampling edges
  always #20 osc = i_run ? ~osc : osc;
  // Crystal input grounded when the pin carries an applied clock
  assign o_xtal = i_ext_mode ? 1'b0 : osc;
  // Pull-down on the pin in crystal mode, so an idle pin reads low
  assign o_pin = i_ext_mode ? osc : (i_pin_oe ? i_pin_out : 1'b0);
endmodule

// File: system_clock_select_control_tb_top.sv
`timescale 1ns/1ns
module system_clock_select_control_tb_top;
  import scc_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic ce = 1'b1;
  logic ext_mode = 1'b0;
  logic run = 1'b1;
  logic sw_mode = 1'b0;
  logic ctrl_wr = 1'b0;
  logic oe_en = 1'b1;
  logic halve = 1'b0;
  logic gpd = 1'b1;
  logic sclk = 1'b0;
  logic lrck = 1'b0;
  logic sdin = 1'b0;
  logic [1:0] fsel = 2'h0;
  logic [1:0] exp_freq;
  logic pin, xtal, mc_out, mc_oe, xo, src_ok, ready;
  logic [1:0] src, freq_eff, rate;
  logic [2:0] audio;
  int bad_count = 0;
  int check_count = 0;
  int seed = 32'h60f0;
  int cyc, t0, t1;

  scc_top #(.DECIDE_CYC(200)) DUT (.i_clock(i_clock), .i_rst(i_rst), .i_ce(ce),
    .i_master_clock_pin(pin), .i_crystal_in_pin(xtal), .i_sw_mode(sw_mode),
    .i_ctrl_wr(ctrl_wr), .i_nominal_freq_select(fsel), .i_clock_out_enable(oe_en),
    .i_clock_out_halve(halve), .i_global_power_down(gpd), .i_sclk(sclk), .i_lrck(lrck),
    .i_sdin(sdin), .o_master_clock_pin(mc_out), .o_master_clock_oe(mc_oe),
    .o_crystal_out_pin(xo), .o_src(src), .o_src_valid(src_ok), .o_freq_eff(freq_eff),
    .o_ctrl_ready(ready), .o_audio_sync(audio), .o_rate(rate));
  scc_src_model model (.i_ext_mode(ext_mode), .i_run(run), .i_pin_oe(mc_oe),
    .i_pin_out(mc_out), .o_pin(pin), .o_xtal(xtal));

  // Free-running 100 MHz clock
  initial begin
    forever #5 i_clock = ~i_clock;
  end
  // Cycles since reset release
  always @(posedge i_clock or posedge i_rst) begin
    cyc <= i_rst ? 0 : cyc + 1;
  end
  // Reserved code reads back as the first code
  function automatic logic [1:0] exp_fn(input logic [1:0] d);
    return (d == SCC_FREQ_RSVD) ? SCC_FREQ_18M432 : d;
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Reset for 6 cycles; nothing may be driven or chosen meanwhile
  task automatic do_reset(input logic ext);
    @(negedge i_clock);
    ext_mode = ext;
    run = 1'b1;
    gpd = 1'b1;
    i_rst = 1'b1;
    repeat (6) @(negedge i_clock);
    chk({mc_oe, xo, src}, 4'h0, "in reset");
    i_rst = 1'b0;
  endtask
  // Pin toggles over 400 cycles
  task automatic count_tog(output int t);
    logic last;
    t = 0;
    last = mc_out;
    repeat (400) begin
      @(negedge i_clock);
      t += (mc_out !== last) ? 1 : 0;
      last = mc_out;
    end
  endtask

  initial begin
    do_reset(1'b0);
    // Host holds off until the control port is ready
    while (ready !== 1'b1 && cyc < 100) @(negedge i_clock);
    chk({3'h0, cyc >= 49 && cyc <= 52}, 4'h1, "ready time");
    chk({2'h0, freq_eff}, {2'h0, SCC_FREQ_RESET}, "freq reset");
    exp_freq = SCC_FREQ_RESET;
    // Every code first, then random codes; strobe held high, one write per edge
    for (int i = 0; i < 40; i++) begin
      fsel = (i < 4) ? i[1:0] : 2'($random(seed));
      sw_mode = (i < 4) ? 1'b1 : 1'($random(seed));
      ctrl_wr = 1'b1;
      @(negedge i_clock);
      exp_freq = sw_mode ? exp_fn(fsel) : exp_freq;
      chk({2'h0, freq_eff}, {2'h0, exp_freq}, "freq");
    end
    // Frozen enable refuses a software-mode write
    ce = 1'b0;
    sw_mode = 1'b1;
    fsel = (exp_freq == SCC_FREQ_24M576) ? SCC_FREQ_27M000 : SCC_FREQ_24M576;
    @(negedge i_clock);
    chk({2'h0, freq_eff}, {2'h0, exp_freq}, "freq frozen");
    ce = 1'b1;
    ctrl_wr = 1'b0;
    while (cyc < 260) @(negedge i_clock);
    chk({2'h0, src}, {2'h0, SCC_SRC_XTAL}, "crystal chosen");
    // Oscillator edges fall on falling clock edges, so look a little later
    #2 chk({3'h0, xo}, {3'h0, ~xtal}, "driver follows crystal");
    chk({3'h0, mc_oe}, 4'h0, "early clock out");
    // 1024 crystal periods of 4 cycles, plus edge sampling
    while (mc_oe !== 1'b1 && cyc < 6000) @(negedge i_clock);
    chk({3'h0, cyc >= 4088 && cyc <= 4112}, 4'h1, "start time");
    count_tog(t0);
    halve = 1'b1;
    count_tog(t1);
    chk({3'h0, t0 >= 196 && t0 <= 204}, 4'h1, "full rate");
    chk({3'h0, t1 >= 96 && t1 <= 104}, 4'h1, "half rate");
    oe_en = 1'b0;
    @(negedge i_clock);
    chk({2'h0, mc_oe, mc_out}, 4'h0, "pin released");
    $display("Test crystal done");
    // 200-cycle frames for the first window, then 300-cycle frames
    gpd = 1'b0;
    for (int i = 0; i < 160; i++) begin
      lrck = ~lrck;
      {sclk, sdin} = 2'($random(seed));
      repeat ((i < 64) ? 100 : 150) @(negedge i_clock);
      chk({1'h0, audio}, {1'h0, sclk, lrck, sdin}, "audio sync");
      if (i == 63) chk({2'h0, rate}, {2'h0, SCC_RATE_96K}, "rate fast");
    end
    chk({2'h0, rate}, {2'h0, SCC_RATE_48K}, "rate slow");
    chk({2'h0, src}, {2'h0, SCC_SRC_XTAL}, "source held");
    $display("Test audio done");
    do_reset(1'b1);
    repeat (40) @(negedge i_clock);
    chk({src_ok, xo, src}, {2'h2, SCC_SRC_EXT}, "applied clock");
    run = 1'b0;
    oe_en = 1'b1;
    repeat (300) @(negedge i_clock);
    chk({mc_oe, 1'b0, src}, {2'h0, SCC_SRC_EXT}, "no switch");
    $display("Test applied clock done");
    end_sim();
  end
  // Hang guard, about twice the expected run
  initial begin
    #550000;
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim();
  end
endmodule
